// *** twcr_defs.svh ***
/*
  Constants of the transceiver and wake configuration registers: register
  indices, field positions, reset values, read masks and timing counts.
  Assumes inclusion by bare name from design files.
*/
`ifndef TWCR_DEFS_SVH
`define TWCR_DEFS_SVH

`define TWCR_ADDR_BUS       7'h04
`define TWCR_ADDR_INT       7'h06
`define TWCR_ADDR_EXT       7'h07
`define TWCR_ADDR_PULL      7'h08

`define TWCR_BUS_OFF        2'h0
`define TWCR_BUS_WAKE       2'h1
`define TWCR_BUS_RXONLY     2'h2
`define TWCR_BUS_NORMAL     2'h3

`define TWCR_RST_BUS        8'h00
`define TWCR_RST_INT        8'h00
`define TWCR_RST_EXT        8'h01
`define TWCR_RST_PULL       8'h00

`define TWCR_MASK_BUS       8'h03
`define TWCR_MASK_INT       8'h44
`define TWCR_MASK_EXT       8'ha1
`define TWCR_MASK_PULL      8'hc3

`define TWCR_BIT_TIMER_WK   6
`define TWCR_BIT_STOP_HI    2
`define TWCR_BIT_GLOBAL     7
`define TWCR_BIT_MEAS       5
`define TWCR_BIT_HV_INPUT_WAKE_ENABLE      0

`define TWCR_PULL_NONE      2'h0
`define TWCR_PULL_DOWN      2'h1
`define TWCR_PULL_UP        2'h2
`define TWCR_PULL_AUTO      2'h3

`define TWCR_CLK_NS         5
`define TWCR_INT_PULSE_NS   100
`define TWCR_INT_PULSE_CYC  ((`TWCR_INT_PULSE_NS + `TWCR_CLK_NS - 1) / `TWCR_CLK_NS)

`endif

// *** twcr_host.sv ***
/*
  Host model that reaches the register bank with single write and read
  pulses on the shared clock.
  Assumes the bank answers a read one cycle after it is taken.
*/
`include "twcr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module twcr_host
  import twcr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reg_rd_valid_ff,
  input  wire twcr_byte_t reg_rdata_ff,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output twcr_addr_t      reg_addr,
  output twcr_byte_t      reg_wdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 7'h7f;
    reg_wdata = 8'h5a;
  end

  // released address and data show the inverse, never the last value
  task automatic reg_write(input twcr_addr_t a, input twcr_byte_t d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : reg_write

  task automatic reg_read(input twcr_addr_t a, output twcr_byte_t d, output logic v);
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    #1;
    d = reg_rdata_ff;
    v = reg_rd_valid_ff;
  endtask : reg_read

  task automatic select_bus_wake();
    reg_write(`TWCR_ADDR_BUS, {6'h00, `TWCR_BUS_WAKE});
  endtask : select_bus_wake
endmodule : twcr_host
`default_nettype wire

// *** twcr_pkg.sv ***
/*
  Types shared by the transceiver and wake configuration register bank.
  Assumes nothing of its surroundings.
*/
package twcr_pkg;
  typedef logic [7:0] twcr_byte_t;
  typedef logic [6:0] twcr_addr_t;
  typedef logic [1:0] twcr_code_t;
  typedef logic [7:0] twcr_count_t;
endpackage : twcr_pkg

// *** twcr_regs.sv ***
/*
  Transceiver mode, internal wake, external wake and pull configuration
  registers with their hardware overrides, wake qualification and the
  interrupt output.
  Assumes a serial frame decoder on the same clock delivering register
  accesses, and device mode logic delivering fail-safe, restart, soft reset
  and mode levels on the same clock. Only the two pin levels are foreign.
*/
// Function
// - transceiver mode codes 0..3 mean off, wake capable, receive only, normal.
// - fail-safe entry forces the transceiver mode to wake capable.
// - after restart the transceiver mode takes the cause-dependent value supplied.
// - in development mode power-on and soft reset load normal mode.
// - timer events wake only when the timer wake enable bit is set.
// - second stop watchdog bit one switches watchdog off in stop mode only when the first bit is also one.
// - both stop watchdog bits together decide watchdog off in stop mode.
// - hardware clears second stop watchdog bit on stop to normal change.
// - global interrupt bit zero lets only wake events drive the interrupt.
// - global interrupt bit one lets every status flag drive the interrupt.
// - measurement selected means the high-voltage input produces no wake events.
// - measurement selected without failure output ignores wake enable and aux config.
// - write setting measurement during failure output is refused and flags failure.
// - measurement in normal mode enables sensing and holds level bits reset.
// - high-voltage input wakes only when its wake enable bit is set.
// - fail-safe entry without measurement sets wake enable, keeping global and measure.
// - fail-safe entry with measurement leaves the input out of wake sources.
// - aux pin pull selection applies only when aux pin is a wake input.
// - pull codes 0..3 mean none, pull-down, pull-up, automatic switching.
// - reserved bits always read back as zero.
`include "twcr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module twcr_regs
  import twcr_pkg::*;
#(
  parameter twcr_count_t INT_PULSE = twcr_count_t'(`TWCR_INT_PULSE_CYC)
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire twcr_addr_t reg_addr,
  input  wire twcr_byte_t reg_wdata,
  input  wire logic       soft_reset,
  input  wire logic       dev_mode,
  input  wire logic       failsafe_entry,
  input  wire logic       restart_entry,
  input  wire twcr_code_t restart_bus_mode,
  input  wire logic       normal_mode,
  input  wire logic       stop_to_normal,
  input  wire logic       failure_output,
  input  wire logic       stop_watchdog_off_lo,
  input  wire logic       aux_pin_is_wake,
  input  wire logic       timer_event,
  input  wire logic       bus_wake_event,
  input  wire logic       status_event,
  input  wire logic       hv_wake_input,
  input  wire logic       aux_pin_input,
  output logic            reg_rd_valid_ff,
  output twcr_byte_t      reg_rdata_ff,
  output logic            spi_fail_set_ff,
  output logic            bus_off_ff,
  output logic            bus_wake_capable_ff,
  output logic            bus_rx_only_ff,
  output logic            bus_normal_ff,
  output logic            watchdog_stop_off_ff,
  output logic            wake_event_ff,
  output logic            interrupt_out_n_ff,
  output logic            measure_enable_ff,
  output logic            hv_input_level_ff,
  output logic            aux_pin_level_ff,
  output logic [2:0]      hv_input_pull_ff,
  output logic [2:0]      aux_pin_pull_ff
);

  // pull decode: {auto, up, down}, all off unless applied
  function automatic logic [2:0] pull_decode(input twcr_code_t code, input logic apply);
    logic [2:0] res;
    res = 3'h0;
    if (apply) begin
      case (code)
        `TWCR_PULL_DOWN: res = 3'h1;
        `TWCR_PULL_UP:   res = 3'h2;
        `TWCR_PULL_AUTO: res = 3'h4;
        default:         res = 3'h0;
      endcase
    end
    return res;
  endfunction : pull_decode

  function automatic logic addr_hit(input twcr_addr_t a, input twcr_addr_t target);
    return a == target;
  endfunction : addr_hit

  twcr_code_t  bus_mode_ff;
  logic        timer_wake_enable_ff;
  logic        stop_watchdog_off_hi_ff;
  logic        int_global_ff;
  logic        sense_measure_select_ff;
  logic        hv_input_wake_enable_ff;
  twcr_code_t  hv_input_pull_select_ff;
  twcr_code_t  aux_pin_pull_select_ff;
  logic        init_pending_ff;
  logic        hv_sync1_ff;
  logic        hv_sync2_ff;
  logic        hv_prev_ff;
  logic        aux_sync1_ff;
  logic        aux_sync2_ff;
  twcr_count_t int_cnt_ff;
  twcr_count_t nxt_int_cnt;
  twcr_byte_t  nxt_rdata;
  logic        wr_bus;
  logic        wr_int;
  logic        wr_ext;
  logic        wr_pull;
  logic        meas_refused;
  logic        meas_overrides;
  logic        hv_change;
  logic        nxt_wake_event;
  logic        int_trigger;

  assign wr_bus         = reg_wr_en && addr_hit(reg_addr, `TWCR_ADDR_BUS);
  assign wr_int         = reg_wr_en && addr_hit(reg_addr, `TWCR_ADDR_INT);
  assign wr_ext         = reg_wr_en && addr_hit(reg_addr, `TWCR_ADDR_EXT);
  assign wr_pull        = reg_wr_en && addr_hit(reg_addr, `TWCR_ADDR_PULL);
  assign meas_refused   = wr_ext && reg_wdata[`TWCR_BIT_MEAS] && failure_output;
  assign meas_overrides = sense_measure_select_ff && !failure_output;

  // pin synchronisers; the second stage is read, and for the high-voltage input also a third stage for edge detection
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hv_sync1_ff  <= 1'b0;
      hv_sync2_ff  <= 1'b0;
      hv_prev_ff   <= 1'b0;
      aux_sync1_ff <= 1'b0;
      aux_sync2_ff <= 1'b0;
    end else begin
      hv_sync1_ff  <= hv_wake_input;
      hv_sync2_ff  <= hv_sync1_ff;
      hv_prev_ff   <= hv_sync2_ff;
      aux_sync1_ff <= aux_pin_input;
      aux_sync2_ff <= aux_sync1_ff;
    end
  end

  assign hv_change = hv_sync2_ff ^ hv_prev_ff;

  // development mode level is caught at the first edge after reset release
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      init_pending_ff <= 1'b1;
    end else begin
      init_pending_ff <= 1'b0;
    end
  end

  // transceiver mode; priority fail-safe, restart, reset load, write
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bus_mode_ff <= 2'(`TWCR_RST_BUS);
    end else if (failsafe_entry) begin
      bus_mode_ff <= `TWCR_BUS_WAKE;
    end else if (restart_entry) begin
      bus_mode_ff <= restart_bus_mode;
    end else if (init_pending_ff || soft_reset) begin
      bus_mode_ff <= dev_mode ? `TWCR_BUS_NORMAL : `TWCR_BUS_OFF;
    end else if (wr_bus) begin
      bus_mode_ff <= reg_wdata[1:0];
    end
  end

  // internal wake register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timer_wake_enable_ff    <= 1'(`TWCR_RST_INT >> `TWCR_BIT_TIMER_WK);
      stop_watchdog_off_hi_ff <= 1'(`TWCR_RST_INT >> `TWCR_BIT_STOP_HI);
    end else if (soft_reset) begin
      timer_wake_enable_ff    <= 1'(`TWCR_RST_INT >> `TWCR_BIT_TIMER_WK);
      stop_watchdog_off_hi_ff <= 1'(`TWCR_RST_INT >> `TWCR_BIT_STOP_HI);
    end else if (wr_int) begin
      // a write in the same cycle as the hardware clear wins
      timer_wake_enable_ff    <= reg_wdata[`TWCR_BIT_TIMER_WK];
      stop_watchdog_off_hi_ff <= reg_wdata[`TWCR_BIT_STOP_HI];
    end else if (stop_to_normal) begin
      stop_watchdog_off_hi_ff <= 1'b0;
    end
  end

  // external wake register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      int_global_ff           <= 1'(`TWCR_RST_EXT >> `TWCR_BIT_GLOBAL);
      sense_measure_select_ff <= 1'(`TWCR_RST_EXT >> `TWCR_BIT_MEAS);
      hv_input_wake_enable_ff <= 1'(`TWCR_RST_EXT >> `TWCR_BIT_HV_INPUT_WAKE_ENABLE);
    end else if (soft_reset) begin
      int_global_ff           <= 1'(`TWCR_RST_EXT >> `TWCR_BIT_GLOBAL);
      sense_measure_select_ff <= 1'(`TWCR_RST_EXT >> `TWCR_BIT_MEAS);
      hv_input_wake_enable_ff <= 1'(`TWCR_RST_EXT >> `TWCR_BIT_HV_INPUT_WAKE_ENABLE);
    end else if (failsafe_entry) begin
      if (!sense_measure_select_ff) begin
        hv_input_wake_enable_ff <= 1'b1;
      end
      // with measurement selected nothing changes here
    end else if (wr_ext) begin
      int_global_ff           <= reg_wdata[`TWCR_BIT_GLOBAL];
      hv_input_wake_enable_ff <= reg_wdata[`TWCR_BIT_HV_INPUT_WAKE_ENABLE];
      if (!meas_refused) begin
        sense_measure_select_ff <= reg_wdata[`TWCR_BIT_MEAS];
      end
    end
  end

  // pull selection register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hv_input_pull_select_ff <= 2'(`TWCR_RST_PULL);
      aux_pin_pull_select_ff  <= 2'(`TWCR_RST_PULL >> 6);
    end else if (soft_reset) begin
      hv_input_pull_select_ff <= 2'(`TWCR_RST_PULL);
      aux_pin_pull_select_ff  <= 2'(`TWCR_RST_PULL >> 6);
    end else if (wr_pull) begin
      hv_input_pull_select_ff <= reg_wdata[1:0];
      aux_pin_pull_select_ff  <= reg_wdata[7:6];
    end
  end

  // read path; reserved bits and unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `TWCR_ADDR_BUS:  nxt_rdata = {6'h00, bus_mode_ff} & `TWCR_MASK_BUS;
      `TWCR_ADDR_INT:  nxt_rdata = {1'b0, timer_wake_enable_ff, 3'h0,
                                    stop_watchdog_off_hi_ff, 2'h0} & `TWCR_MASK_INT;
      `TWCR_ADDR_EXT:  nxt_rdata = {int_global_ff, 1'b0, sense_measure_select_ff,
                                    4'h0, hv_input_wake_enable_ff} & `TWCR_MASK_EXT;
      `TWCR_ADDR_PULL: nxt_rdata = {aux_pin_pull_select_ff, 4'h0,
                                    hv_input_pull_select_ff} & `TWCR_MASK_PULL;
      default:         nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rd_valid_ff <= 1'b0;
      reg_rdata_ff    <= 8'h00;
      spi_fail_set_ff <= 1'b0;
    end else begin
      reg_rd_valid_ff <= reg_rd_en;
      reg_rdata_ff    <= reg_rd_en ? nxt_rdata : reg_rdata_ff;
      spi_fail_set_ff <= meas_refused;
    end
  end

  // mode decode and watchdog stop control
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bus_off_ff           <= 1'b1;
      bus_wake_capable_ff  <= 1'b0;
      bus_rx_only_ff       <= 1'b0;
      bus_normal_ff        <= 1'b0;
      watchdog_stop_off_ff <= 1'b0;
    end else begin
      bus_off_ff           <= bus_mode_ff == `TWCR_BUS_OFF;
      bus_wake_capable_ff  <= bus_mode_ff == `TWCR_BUS_WAKE;
      bus_rx_only_ff       <= bus_mode_ff == `TWCR_BUS_RXONLY;
      bus_normal_ff        <= bus_mode_ff == `TWCR_BUS_NORMAL;
      watchdog_stop_off_ff <= stop_watchdog_off_hi_ff && stop_watchdog_off_lo;
    end
  end

  // wake qualification
  assign nxt_wake_event = (timer_event && timer_wake_enable_ff)
                       || (hv_change && hv_input_wake_enable_ff
                           && !sense_measure_select_ff)
                       || (bus_wake_event && bus_mode_ff == `TWCR_BUS_WAKE);

  assign int_trigger = wake_event_ff || (int_global_ff && status_event);

  always_comb begin
    nxt_int_cnt = int_cnt_ff;
    if (int_trigger) begin
      nxt_int_cnt = INT_PULSE;
    end else if (int_cnt_ff != 8'h00) begin
      nxt_int_cnt = int_cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wake_event_ff      <= 1'b0;
      int_cnt_ff         <= 8'h00;
      interrupt_out_n_ff <= 1'b1;
    end else begin
      wake_event_ff      <= nxt_wake_event;
      int_cnt_ff         <= nxt_int_cnt;
      interrupt_out_n_ff <= nxt_int_cnt == 8'h00;
    end
  end

  // sensing, level status and pull controls
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      measure_enable_ff <= 1'b0;
      hv_input_level_ff <= 1'b0;
      aux_pin_level_ff  <= 1'b0;
      hv_input_pull_ff  <= 3'h0;
      aux_pin_pull_ff   <= 3'h0;
    end else begin
      measure_enable_ff <= sense_measure_select_ff && normal_mode;
      hv_input_level_ff <= sense_measure_select_ff ? 1'b0 : hv_sync2_ff;
      aux_pin_level_ff  <= sense_measure_select_ff ? 1'b0 : aux_sync2_ff;
      hv_input_pull_ff  <= pull_decode(hv_input_pull_select_ff, 1'b1);
      aux_pin_pull_ff   <= pull_decode(aux_pin_pull_select_ff,
                                       aux_pin_is_wake && !meas_overrides);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_fs_entry;
    failsafe_entry && !sense_measure_select_ff;
  endsequence

  sequence s_wake_seen;
    ##1 bus_wake_capable_ff;
  endsequence

  a_failsafe_bus_wake: assert property (failsafe_entry |=> s_wake_seen)
    else $error("fail-safe entry did not give wake capable mode");

  a_failsafe_hv_input_wake_enable: assert property (s_fs_entry |=> hv_input_wake_enable_ff
                                     && $stable(int_global_ff))
    else $error("fail-safe entry did not set wake enable");

  a_meas_refused: assert property (meas_refused && !sense_measure_select_ff
                                   |=> spi_fail_set_ff && !sense_measure_select_ff)
    else $error("measurement write during failure not refused");

  a_stop_hi_clear: assert property (stop_to_normal && !wr_int && !soft_reset
                                    |=> !stop_watchdog_off_hi_ff)
    else $error("stop watchdog bit not cleared");

  a_watchdog_pair: assert property (stop_watchdog_off_hi_ff && stop_watchdog_off_lo
                                    |=> watchdog_stop_off_ff)
    else $error("watchdog not off with both bits set");

  a_meas_no_wake: assert property (sense_measure_select_ff && !timer_event
                                   && !bus_wake_event |=> !wake_event_ff)
    else $error("wake from input while measuring");

  a_global_off: assert property (!int_global_ff && int_cnt_ff == 8'h00 && !wake_event_ff
                                 |=> interrupt_out_n_ff)
    else $error("interrupt without wake event");

  a_global_on: assert property (int_global_ff && status_event
                                |=> !interrupt_out_n_ff [*2])
    else $error("status flag did not raise interrupt");

  a_timer_wake: assert property (timer_event && !timer_wake_enable_ff && !bus_wake_event
                                 && !hv_change |=> !wake_event_ff)
    else $error("timer wake while disabled");

  a_level_hold: assert property (sense_measure_select_ff |=> !hv_input_level_ff
                                 && !aux_pin_level_ff)
    else $error("level status updated while measuring");

  a_reserved_zero: assert property (reg_rd_en |=> (reg_rdata_ff & ~(`TWCR_MASK_BUS
                                    | `TWCR_MASK_INT | `TWCR_MASK_EXT | `TWCR_MASK_PULL)) == 8'h00)
    else $error("reserved bits read non-zero");

  a_aux_pull_gate: assert property (!aux_pin_is_wake |=> aux_pin_pull_ff == 3'h0)
    else $error("aux pull applied while not a wake input");

endmodule : twcr_regs

`default_nettype wire

// *** twcr_regs_tb.sv ***
/*
  Self-checking bench for the transceiver and wake configuration registers.
  Assumes the host model drives the register port; the bench drives the rest.
*/
`include "twcr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module twcr_regs_tb
  import twcr_pkg::*;
;
  logic clock = 1'b0, reset = 1'b1;
  logic wr_en, rd_en, rd_valid, spi_fail, b_off, b_wk, b_rx, b_nrm, wd_off;
  logic wake_ev, int_n, meas_en, hv_lvl, aux_lvl;
  logic soft_reset = 0, dev_mode = 0, failsafe_entry = 0, restart_entry = 0;
  logic normal_mode = 0, stop_to_normal = 0, failure_output = 0, wd_lo = 0;
  logic aux_wake = 0, timer_event = 0, bus_wake_event = 0, status_event = 0;
  logic hv_pin = 0, aux_pin = 0;
  twcr_code_t restart_bus_mode = 2'h0;
  twcr_addr_t addr;
  twcr_byte_t wdata, rdata;
  logic [2:0] hv_pull, aux_pull;
  int fails = 0, comparisons = 0;

  always #2.5 clock = ~clock;

  twcr_host host (.clock(clock), .reg_rd_valid_ff(rd_valid), .reg_rdata_ff(rdata),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata));

  twcr_regs #(.INT_PULSE(twcr_count_t'(4))) uut (.clock(clock), .reset(reset),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .soft_reset(soft_reset), .dev_mode(dev_mode), .failsafe_entry(failsafe_entry),
    .restart_entry(restart_entry), .restart_bus_mode(restart_bus_mode),
    .normal_mode(normal_mode), .stop_to_normal(stop_to_normal),
    .failure_output(failure_output), .stop_watchdog_off_lo(wd_lo),
    .aux_pin_is_wake(aux_wake), .timer_event(timer_event),
    .bus_wake_event(bus_wake_event), .status_event(status_event),
    .hv_wake_input(hv_pin), .aux_pin_input(aux_pin), .reg_rd_valid_ff(rd_valid),
    .reg_rdata_ff(rdata), .spi_fail_set_ff(spi_fail), .bus_off_ff(b_off),
    .bus_wake_capable_ff(b_wk), .bus_rx_only_ff(b_rx), .bus_normal_ff(b_nrm),
    .watchdog_stop_off_ff(wd_off), .wake_event_ff(wake_ev),
    .interrupt_out_n_ff(int_n), .measure_enable_ff(meas_en),
    .hv_input_level_ff(hv_lvl), .aux_pin_level_ff(aux_lvl),
    .hv_input_pull_ff(hv_pull), .aux_pin_pull_ff(aux_pull));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd_chk(input twcr_addr_t a, input twcr_byte_t exp);
    twcr_byte_t d;
    logic       v;
    host.reg_read(a, d, v);
    chk("read valid", {7'h00, v}, 8'h01);
    chk($sformatf("register %h", a), d, exp);
  endtask : rd_chk

  task automatic set_ev(input int sel, input logic v);
    case (sel)
      0: timer_event <= v;
      1: bus_wake_event <= v;
      2: status_event <= v;
      3: if (v) hv_pin <= ~hv_pin;
      4: failsafe_entry <= v;
      5: restart_entry <= v;
      6: soft_reset <= v;
      default: stop_to_normal <= v;
    endcase
  endtask : set_ev

  // one event, then wake pulses and interrupt-low cycles counted over 16 cycles
  task automatic observe(input int sel, output logic [7:0] w, output logic [7:0] n);
    w = 8'h00;
    n = 8'h00;
    @(posedge clock);
    set_ev(sel, 1'b1);
    repeat (16) begin
      @(posedge clock);
      set_ev(sel, 1'b0);
      #1;
      if (wake_ev === 1'b1) w++;
      if (int_n === 1'b0) n++;
    end
  endtask : observe

  task automatic t_reset_values();
    rd_chk(`TWCR_ADDR_BUS, `TWCR_RST_BUS);
    rd_chk(`TWCR_ADDR_INT, `TWCR_RST_INT);
    rd_chk(`TWCR_ADDR_EXT, `TWCR_RST_EXT);
    rd_chk(`TWCR_ADDR_PULL, `TWCR_RST_PULL);
    rd_chk(7'h05, 8'h00);
    chk("bus off", {7'h00, b_off}, 8'h01);
  endtask : t_reset_values

  task automatic t_bus_modes();
    for (int c = 0; c < 4; c++) begin
      host.reg_write(`TWCR_ADDR_BUS, {6'h3f, 2'(c)});
      rd_chk(`TWCR_ADDR_BUS, {6'h00, 2'(c)});
      chk("mode decode", {4'h0, b_nrm, b_rx, b_wk, b_off}, 8'h01 << c);
    end
  endtask : t_bus_modes

  task automatic t_wake_sources();
    logic [7:0] w, n;
    observe(0, w, n);
    chk("timer off wake", w, 8'h00);
    host.reg_write(`TWCR_ADDR_INT, 8'hff);
    rd_chk(`TWCR_ADDR_INT, 8'h44);
    observe(0, w, n);
    chk("timer wake", w, 8'h01);
    chk("wake interrupt", n, 8'h04);
    host.select_bus_wake();
    observe(1, w, n);
    chk("bus wake", w, 8'h01);
    observe(2, w, n);
    chk("status local", n, 8'h00);
    host.reg_write(`TWCR_ADDR_EXT, 8'hdf);
    rd_chk(`TWCR_ADDR_EXT, 8'h81);
    observe(2, w, n);
    chk("status global", n, 8'h04);
    chk("status no wake", w, 8'h00);
    observe(3, w, n);
    chk("hv wake on", w, 8'h01);
    host.reg_write(`TWCR_ADDR_EXT, 8'h80);
    observe(3, w, n);
    chk("hv wake off", w, 8'h00);
  endtask : t_wake_sources

  task automatic t_stop_watchdog();
    logic [7:0] w, n;
    @(posedge clock) wd_lo <= 1'b1;
    host.reg_write(`TWCR_ADDR_INT, 8'h04);
    repeat (2) @(posedge clock);
    #1;
    chk("watchdog off", {7'h00, wd_off}, 8'h01);
    @(posedge clock) wd_lo <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("watchdog pair", {7'h00, wd_off}, 8'h00);
    @(posedge clock) wd_lo <= 1'b1;
    observe(7, w, n);
    rd_chk(`TWCR_ADDR_INT, 8'h00);
    chk("watchdog on", {7'h00, wd_off}, 8'h00);
  endtask : t_stop_watchdog

  task automatic t_measure();
    logic [7:0] w, n;
    @(posedge clock) normal_mode <= 1'b1;
    aux_wake <= 1'b1;
    aux_pin <= 1'b1;
    host.reg_write(`TWCR_ADDR_EXT, 8'h21);
    host.reg_write(`TWCR_ADDR_PULL, 8'h81);
    observe(3, w, n);
    chk("measure no wake", w, 8'h00);
    chk("measure on", {7'h00, meas_en}, 8'h01);
    chk("levels held", {6'h00, hv_lvl, aux_lvl}, 8'h00);
    chk("aux pull ignored", {5'h00, aux_pull}, 8'h00);
    host.reg_write(`TWCR_ADDR_EXT, 8'h01);
    for (int c = 0; c < 4; c++) begin
      host.reg_write(`TWCR_ADDR_PULL, {2'(c), 4'hf, 2'(c)});
      rd_chk(`TWCR_ADDR_PULL, {2'(c), 4'h0, 2'(c)});
      chk("hv pull", {5'h00, hv_pull}, (c == 0) ? 8'h00 : 8'h01 << (c - 1));
      chk("aux pull", {5'h00, aux_pull}, (c == 0) ? 8'h00 : 8'h01 << (c - 1));
    end
    chk("levels live", {6'h00, hv_lvl, aux_lvl}, 8'h03);
    @(posedge clock) aux_wake <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk("aux not wake", {5'h00, aux_pull}, 8'h00);
    @(posedge clock) failure_output <= 1'b1;
    host.reg_write(`TWCR_ADDR_EXT, 8'h21);
    #1;
    chk("spi fail", {7'h00, spi_fail}, 8'h01);
    rd_chk(`TWCR_ADDR_EXT, 8'h01);
    @(posedge clock) failure_output <= 1'b0;
  endtask : t_measure

  task automatic t_overrides();
    logic [7:0] w, n;
    host.reg_write(`TWCR_ADDR_BUS, 8'h03);
    host.reg_write(`TWCR_ADDR_EXT, 8'h80);
    observe(4, w, n);
    rd_chk(`TWCR_ADDR_BUS, 8'h01);
    rd_chk(`TWCR_ADDR_EXT, 8'h81);
    host.reg_write(`TWCR_ADDR_EXT, 8'ha0);
    observe(4, w, n);
    rd_chk(`TWCR_ADDR_EXT, 8'ha0);
    @(posedge clock) restart_bus_mode <= `TWCR_BUS_RXONLY;
    observe(5, w, n);
    rd_chk(`TWCR_ADDR_BUS, 8'h02);
    @(posedge clock) dev_mode <= 1'b1;
    observe(6, w, n);
    rd_chk(`TWCR_ADDR_BUS, 8'h03);
    rd_chk(`TWCR_ADDR_EXT, `TWCR_RST_EXT);
    // power-on load in development mode through a second reset
    @(posedge clock) reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    rd_chk(`TWCR_ADDR_BUS, 8'h03);
  endtask : t_overrides

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset_values();
    t_bus_modes();
    t_wake_sources();
    t_stop_watchdog();
    t_measure();
    t_overrides();
    complete_run();
  end
endmodule : twcr_regs_tb
`default_nettype wire
